//--- core/sfr_regs.sv
// status word and configuration byte logic behind the serial flash pins
`timescale 1ns/1ns
module sfr_regs import sfr_pkg::*; #(
   parameter int unsigned STATUS_WRITE_TIME_NS = 5000000
) (
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // serial pins
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe_o,
   // device mode, same clock domain
   input wire logic four_line_i,
   input wire logic option_d_i,
   input wire logic program_busy_i,
   input wire logic erase_busy_i,
   // state toward the array logic
   output logic [15:0] status_o,
   output sfr_cfg_t cfg_o,
   output sfr_prot_t prot_o,
   output logic write_in_progress_o,
   output logic [1:0] drive_strength_o,
   output logic pin_hold_o,
   output logic pin_reset_o,
   output logic pin_data_o,
   output logic [9:0] page_wrap_mask_o,
   output logic page_erase_o,
   output logic page_erase_wide_o,
   output logic block_lock_preset_o
);
   localparam int unsigned TW_CYCLES =
      (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // combine a byte or word of status write data with the old word
   function automatic logic [15:0] status_apply(input logic [15:0] old, input logic [15:0] d,
                                                input logic wide);
      logic [15:0] cand;
      logic [15:0] res;
      cand = wide ? {d[7:0], d[15:8]} : {old[15:8] & ~BYTE8_CLEAR_MASK[15:8], d[7:0]};
      res = (cand & STATUS_WRITE_MASK) | (old & ~STATUS_WRITE_MASK);
      res[ST_LOCK_LSB +: 3] = res[ST_LOCK_LSB +: 3] | old[ST_LOCK_LSB +: 3];
      return res;
   endfunction

   // shift one or four sampled lines into a register
   function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic [3:0] io,
                                            input logic quad);
      return quad ? {sr[11:0], io} : {sr[14:0], io[0]};
   endfunction

   sfr_pins_t pins_s;
   sfr_pins_t pins_q;
   sfr_pins_t pins_q_next;
   sfr_sync #(.W(6)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i({cs_n_i, sclk_i, io_i}),
      .q_o(pins_s)
   );

   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   logic cs_fall;
   logic [4:0] nbits;
   assign pins_q_next = ce_i ? pins_s : pins_q;
   // edges of the synchronised link signals
   assign sclk_rise = pins_s.sclk & ~pins_q.sclk & ~pins_s.cs_n;
   assign sclk_fall = ~pins_s.sclk & pins_q.sclk & ~pins_s.cs_n;
   assign cs_rise = pins_s.cs_n & ~pins_q.cs_n;
   assign cs_fall = ~pins_s.cs_n & pins_q.cs_n;
   assign nbits = four_line_i ? 5'h04 : 5'h01;

   sfr_state_t state_reg, state_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [7:0] cmd_reg, cmd_next;
   logic [15:0] data_reg, data_next;
   logic [7:0] out_reg, out_next;
   logic out_en_reg, out_en_next;
   logic [15:0] status_reg, status_next;
   sfr_cfg_t cfg_reg, cfg_next;
   logic [31:0] tw_cnt_reg, tw_cnt_next;
   logic wsr_busy_reg, wsr_busy_next;
   logic wip_reg, wip_next;
   logic preset_reg, preset_next;
   logic erase_pulse_reg, erase_pulse_next;
   logic [15:0] status_view;
   logic [4:0] cnt_inc;
   logic [15:0] cmd_shift;
   logic write_blocked;
   logic status_write_op;
   logic status_write_command_accept;
   logic wrcr_accept;
   logic enable_set;

   // live status word with latch and busy folded in
   always_comb begin
      status_view = status_reg;
      status_view[ST_WEL] = status_reg[ST_WEL];
      status_view[ST_WIP] = wip_reg;
   end

   // link state: command shift, data shift, read-out
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cmd_next = cmd_reg;
      data_next = data_reg;
      out_next = out_reg;
      out_en_next = out_en_reg;
      cnt_inc = (cnt_reg > BITS_SAT - nbits) ? BITS_SAT : cnt_reg + nbits;
      cmd_shift = shift_in({8'h00, cmd_reg}, pins_s.io, four_line_i);
      if (!ce_i) begin
         state_next = state_reg;
      end else if (pins_s.cs_n) begin
         state_next = LS_IDLE;
         out_en_next = 1'b0;
      end else if (cs_fall) begin
         state_next = LS_CMD;
         cnt_next = '0;
         out_en_next = 1'b0;
      end else if (sclk_rise) begin
         cnt_next = cnt_inc;
         unique case (state_reg)
            LS_CMD: begin
               cmd_next = cmd_shift[7:0];
               if (cnt_inc == BITS_BYTE) begin
                  cnt_next = '0;
                  state_next = LS_SKIP;
                  if (cmd_shift[7:0] == OP_STATUS_WRITE_A || cmd_shift[7:0] == OP_CONFIG_WRITE
                      || (cmd_shift[7:0] == OP_STATUS_WRITE_B && !option_d_i)) begin
                     state_next = LS_WDATA;
                  end else if (cmd_shift[7:0] == (option_d_i ? OP_CONFIG_READ_D
                                                             : OP_CONFIG_READ)) begin
                     state_next = LS_RDOUT;
                     out_next = cfg_reg;
                  end else if (cmd_shift[7:0] == OP_READ_STATUS_LO) begin
                     state_next = LS_RDOUT;
                     out_next = status_view[7:0];
                  end else if (cmd_shift[7:0] == OP_READ_STATUS_HI) begin
                     state_next = LS_RDOUT;
                     out_next = status_view[15:8];
                  end else if (cmd_shift[7:0] == OP_STATUS_WAIT) begin
                     state_next = LS_WAITOUT;
                     out_en_next = 1'b1;
                     out_next = {wip_reg, 7'h00};
                  end else begin
                     cnt_next = BITS_BYTE;
                  end
               end
            end
            LS_WDATA: data_next = shift_in(data_reg, pins_s.io, four_line_i);
            default: cnt_next = cnt_inc;
         endcase
      end else if (sclk_fall && state_reg == LS_RDOUT) begin
         // first fall puts the msb out, later falls rotate the byte
         if (out_en_reg) begin
            out_next = four_line_i ? {out_reg[3:0], out_reg[7:4]} : {out_reg[6:0], out_reg[7]};
         end
         out_en_next = 1'b1;
      end
      if (ce_i && state_reg == LS_WAITOUT && !pins_s.cs_n) begin
         out_next = {wip_reg, 7'h00};
      end
   end

   // hardware or lock-down protection of the status word
   assign write_blocked = status_reg[ST_SRP_HIGH]
      | (status_reg[ST_SRP_LOW] & ~status_reg[ST_QE] & ~pins_s.io[2]);
   assign status_write_op = (cmd_reg == OP_STATUS_WRITE_A)
      | (cmd_reg == OP_STATUS_WRITE_B & ~option_d_i);
   // busy cycles refuse new writes so a running cycle is never restarted
   assign status_write_command_accept = ce_i & cs_rise & (state_reg == LS_WDATA) & status_write_op
      & (cnt_reg == BITS_BYTE | cnt_reg == BITS_WORD) & status_reg[ST_WEL]
      & ~write_blocked & ~wip_reg;
   assign wrcr_accept = ce_i & cs_rise & (state_reg == LS_WDATA) & (cmd_reg == OP_CONFIG_WRITE)
      & (cnt_reg == BITS_BYTE) & status_reg[ST_WEL] & ~wip_reg;
   assign enable_set = ce_i & cs_rise & (state_reg == LS_SKIP) & (cnt_reg == BITS_BYTE)
      & (cmd_reg == OP_WRITE_ENABLE);

   // register contents, self-timed cycle, suspend flags
   always_comb begin
      status_next = status_reg;
      cfg_next = cfg_reg;
      tw_cnt_next = tw_cnt_reg;
      wsr_busy_next = wsr_busy_reg;
      wip_next = wip_reg;
      preset_next = preset_reg;
      erase_pulse_next = erase_pulse_reg;
      if (ce_i) begin
         preset_next = 1'b0;
         erase_pulse_next = 1'b0;
         wip_next = wsr_busy_reg | program_busy_i | erase_busy_i;
         if (wsr_busy_reg) begin
            if (tw_cnt_reg <= 32'd1) begin
               wsr_busy_next = 1'b0;
               status_next[ST_WEL] = 1'b0;
            end else begin
               tw_cnt_next = tw_cnt_reg - 32'd1;
            end
         end
         if (status_write_command_accept) begin
            status_next = status_apply(status_reg, data_reg, cnt_reg == BITS_WORD);
            wsr_busy_next = 1'b1;
            tw_cnt_next = TW_CYCLES;
         end
         if (wrcr_accept) begin
            cfg_next = data_reg[7:0] & CONFIG_WRITE_MASK;
            wsr_busy_next = 1'b1;
            tw_cnt_next = TW_CYCLES;
         end
         if (cs_rise && state_reg == LS_SKIP && cnt_reg == BITS_BYTE) begin
            unique case (cmd_reg)
               OP_WRITE_DISABLE: status_next[ST_WEL] = 1'b0;
               OP_SUSPEND_A, OP_SUSPEND_B: begin
                  if (erase_busy_i) status_next[ST_ESUS] = 1'b1;
                  if (program_busy_i) status_next[ST_PSUS] = 1'b1;
               end
               OP_RESUME_A, OP_RESUME_B: begin
                  status_next[ST_ESUS] = 1'b0;
                  status_next[ST_PSUS] = 1'b0;
               end
               default: status_next[ST_WEL] = status_next[ST_WEL];
            endcase
         end
         if (cs_rise && state_reg == LS_SKIP && cmd_reg == OP_PAGE_ERASE) begin
            erase_pulse_next = 1'b1;
         end
         // a write enable arriving as the cycle ends still sets the latch
         if (enable_set) begin
            status_next[ST_WEL] = 1'b1;
         end
      end
   end

   // all state registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pins_q <= '1;
         state_reg <= LS_IDLE;
         cnt_reg <= '0;
         cmd_reg <= '0;
         data_reg <= '0;
         out_reg <= '0;
         out_en_reg <= 1'b0;
         status_reg <= STATUS_RESET;
         cfg_reg <= CONFIG_RESET;
         tw_cnt_reg <= '0;
         wsr_busy_reg <= 1'b0;
         wip_reg <= 1'b0;
         preset_reg <= 1'b1;
         erase_pulse_reg <= 1'b0;
      end else begin
         pins_q <= pins_q_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cmd_reg <= cmd_next;
         data_reg <= data_next;
         out_reg <= out_next;
         out_en_reg <= out_en_next;
         status_reg <= status_next;
         cfg_reg <= cfg_next;
         tw_cnt_reg <= tw_cnt_next;
         wsr_busy_reg <= wsr_busy_next;
         wip_reg <= wip_next;
         preset_reg <= preset_next;
         erase_pulse_reg <= erase_pulse_next;
      end
   end

   // pin drivers: single line on io1, four lines in quad read-out
   always_comb begin
      io_o = 4'h0;
      io_oe_o = 4'h0;
      if (out_en_reg && (state_reg == LS_RDOUT || state_reg == LS_WAITOUT)) begin
         if (four_line_i && state_reg == LS_RDOUT) begin
            io_o = out_reg[7:4];
            io_oe_o = 4'hF;
         end else begin
            io_o = {2'b00, out_reg[7], 1'b0};
            io_oe_o = 4'h2;
         end
      end
   end

   // decoded configuration toward the rest of the device
   assign status_o = status_view;
   assign cfg_o = cfg_reg;
   assign write_in_progress_o = wip_reg;
   assign prot_o = '{scheme: cfg_reg.scheme, complement: status_reg[ST_CMP],
      block_protect: status_reg[6:2], sec_lock: status_reg[ST_LOCK_LSB +: 3]};
   assign drive_strength_o = option_d_i ? CONFIG_RESET[CF_DRV_LSB +: 2] : cfg_reg.drive;
   assign pin_data_o = status_reg[ST_QE];
   assign pin_hold_o = ~status_reg[ST_QE] & ~cfg_reg.hold_reset_sel;
   assign pin_reset_o = ~status_reg[ST_QE] & cfg_reg.hold_reset_sel;
   assign page_wrap_mask_o = cfg_reg.wide_page ? PAGE_WRAP_WIDE : PAGE_WRAP_SMALL;
   assign page_erase_o = erase_pulse_reg;
   assign page_erase_wide_o = cfg_reg.wide_page;
   assign block_lock_preset_o = preset_reg;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_wsr_start;
      ce_i && status_write_command_accept;
   endsequence
   sequence s_wsr_short;
      ce_i && status_write_command_accept && cnt_reg == BITS_BYTE;
   endsequence

   property p_lock_otp;
      ($past(status_reg[13:11]) & ~status_reg[13:11]) == 3'h0;
   endproperty
   a_lock_otp: assert property (p_lock_otp) else $error("lock bit cleared");

   property p_wait_no_rise;
      state_reg == LS_WAITOUT && $past(state_reg) == LS_WAITOUT && ce_i |-> !$rose(io_o[1]);
   endproperty
   a_wait_no_rise: assert property (p_wait_no_rise) else $error("wait output rose");

   property p_cs_release;
      ce_i && pins_s.cs_n |=> io_oe_o == 4'h0;
   endproperty
   a_cs_release: assert property (p_cs_release) else $error("output kept after cs high");

   property p_need_latch;
      ce_i && cs_rise && state_reg == LS_WDATA && !status_reg[ST_WEL] && !wsr_busy_reg
         |=> !wsr_busy_reg;
   endproperty
   a_need_latch: assert property (p_need_latch) else $error("write without latch");

   property p_keep_bits;
      s_wsr_start |=> status_reg[ST_ESUS] == $past(status_reg[ST_ESUS])
         && status_reg[ST_PSUS] == $past(status_reg[ST_PSUS]);
   endproperty
   a_keep_bits: assert property (p_keep_bits) else $error("suspend bit changed by write");

   property p_byte8_clear;
      s_wsr_short |=> !status_reg[ST_CMP] && !status_reg[ST_QE] && !status_reg[ST_SRP_HIGH];
   endproperty
   a_byte8_clear: assert property (p_byte8_clear) else $error("byte write kept bits");

   property p_cycle_busy;
      s_wsr_start ##1 ce_i |=> wsr_busy_reg[*8] ##1 wip_reg;
   endproperty
   a_cycle_busy: assert property (p_cycle_busy) else $error("write cycle ended early");

   property p_latch_clear;
      ce_i && $fell(wsr_busy_reg) && !$past(enable_set) |-> !status_reg[ST_WEL];
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch kept after cycle");

   property p_hw_protect;
      ce_i && cs_rise && state_reg == LS_WDATA && status_write_op && write_blocked
         && !wsr_busy_reg |=> !wsr_busy_reg;
   endproperty
   a_hw_protect: assert property (p_hw_protect) else $error("write under protection");

   property p_preset;
      $fell(rst_i) |-> block_lock_preset_o;
   endproperty
   a_preset: assert property (@(posedge clk_sys_i) p_preset) else $error("no lock preset");
endmodule // sfr_regs

//--- core/sfr_pkg.sv
// package: opcodes, field positions, reset values and types of the flash status/config registers
package sfr_pkg;
   localparam int CLK_PERIOD_NS = 8;
   // command codes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
   localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
   localparam logic [7:0] OP_STATUS_WRITE_A = 8'h01;
   localparam logic [7:0] OP_STATUS_WRITE_B = 8'h31;
   localparam logic [7:0] OP_CONFIG_WRITE = 8'h11;
   localparam logic [7:0] OP_CONFIG_READ = 8'h15;
   localparam logic [7:0] OP_CONFIG_READ_D = 8'h45;
   localparam logic [7:0] OP_STATUS_WAIT = 8'h25;
   localparam logic [7:0] OP_SUSPEND_A = 8'h75;
   localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
   localparam logic [7:0] OP_RESUME_A = 8'h7A;
   localparam logic [7:0] OP_RESUME_B = 8'h30;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   // status word bit positions
   localparam int ST_WIP = 0;
   localparam int ST_WEL = 1;
   localparam int ST_SRP_LOW = 7;
   localparam int ST_SRP_HIGH = 8;
   localparam int ST_QE = 9;
   localparam int ST_PSUS = 10;
   localparam int ST_LOCK_LSB = 11;
   localparam int ST_CMP = 14;
   localparam int ST_ESUS = 15;
   // configuration byte bit positions
   localparam int CF_HOLD_RST = 7;
   localparam int CF_DRV_LSB = 5;
   localparam int CF_WIDE_PAGE = 4;
   localparam int CF_SCHEME = 2;
   // reset values and write masks
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [7:0] CONFIG_RESET = 8'h40;
   localparam logic [15:0] STATUS_WRITE_MASK = 16'h7BFC;
   localparam logic [15:0] BYTE8_CLEAR_MASK = 16'h4300;
   localparam logic [2:0] LOCK_MASK = 3'h7;
   localparam logic [7:0] CONFIG_WRITE_MASK = 8'hF4;
   localparam logic [9:0] PAGE_WRAP_SMALL = 10'h0FF;
   localparam logic [9:0] PAGE_WRAP_WIDE = 10'h3FF;
   // link bit counts
   localparam logic [4:0] BITS_BYTE = 5'h08;
   localparam logic [4:0] BITS_WORD = 5'h10;
   localparam logic [4:0] BITS_SAT = 5'h1F;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic [3:0] io;
   } sfr_pins_t;

   typedef struct packed {
      logic hold_reset_sel;
      logic [1:0] drive;
      logic wide_page;
      logic rsvd3;
      logic scheme;
      logic rsvd1;
      logic rsvd0;
   } sfr_cfg_t;

   typedef struct packed {
      logic scheme;
      logic complement;
      logic [4:0] block_protect;
      logic [2:0] sec_lock;
   } sfr_prot_t;

   typedef enum logic [2:0] {
      LS_IDLE = 3'b000,
      LS_CMD = 3'b001,
      LS_WDATA = 3'b010,
      LS_RDOUT = 3'b011,
      LS_WAITOUT = 3'b100,
      LS_SKIP = 3'b101
   } sfr_state_t;
endpackage

//--- core/sfr_sync.sv
// two-flop synchroniser for pins arriving from outside the system clock
`timescale 1ns/1ns
module sfr_sync #(
   parameter int W = 6
) (
   // clock and control
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // first stage feeds only the second stage
   always_comb begin
      meta_next = ce_i ? d_i : meta_reg;
      q_next = ce_i ? meta_reg : q_reg;
   end

   // idle pin level is high so chip select starts deasserted
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         meta_reg <= '1;
         q_reg <= '1;
      end else begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule // sfr_sync

//--- tb/sfr_host.sv
// host controller model driving the serial flash link in mode 0
`timescale 1ns/1ns
module sfr_host (
   // clock
   input wire logic clk_sys_i,
   // link pins
   output logic cs_n_o,
   output logic sclk_o,
   output logic io0_o,
   input wire logic so_i
);
   // link clock stands low between frames
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      io0_o = 1'b1;
   end
   // one link clock phase: four system cycles, 64 ns period
   task automatic half();
      repeat (4) @(negedge clk_sys_i);
   endtask
   // release select; the data line shows the inverse of its last value
   task automatic cs_up();
      cs_n_o = 1'b1;
      io0_o = ~io0_o;
      half();
      half();
   endtask
   // opcode, nw data bits msb first, nr read bits; mode 0 needs no dummy bit
   task automatic xfer(input logic [7:0] op, input logic [15:0] pay, input int nw,
                       input int nr, input bit keep, output logic [7:0] rd);
      logic [23:0] sh;
      sh = {op, pay};
      rd = 8'h00;
      @(negedge clk_sys_i);
      cs_n_o = 1'b0;
      for (int i = 0; i < 8 + nw + nr; i++) begin
         io0_o = (i < 8 + nw) ? sh[23] : ~io0_o;
         sh = sh << 1;
         half();
         sclk_o = 1'b1;
         half();
         if (i >= 8 + nw) rd = {rd[6:0], so_i};
         sclk_o = 1'b0;
      end
      half();
      // select rises one phase, four system cycles, after the last falling clock edge
      if (!keep) cs_up();
   endtask
endmodule // sfr_host

//--- tb/serial_flash_status_config_regs_tb.sv
// self-checking bench for the flash status and configuration register block
`timescale 1ns/1ns
module serial_flash_status_config_regs_tb;
   import sfr_pkg::*;
   localparam int TW_NS = 2000;
   logic ce, clk_sys_i, rst_i, wp_n, opt_d, pbusy, ebusy, idle_pat, cs_n, sclk, io0, so_line;
   logic [3:0] io_o, io_oe_o;
   logic [15:0] status_o, exp_st;
   sfr_cfg_t cfg_o;
   sfr_prot_t prot_o;
   logic write_in_progress, hold, rstp, pe, pe_wide, preset;
   logic [1:0] drv;
   logic [9:0] wrap;
   logic [7:0] exp_cfg, rd;
   logic [31:0] seed;
   int bad_count, samples_checked, cycles, pe_count;
   // a released return line toggles, so a stale value never looks valid
   assign so_line = io_oe_o[1] ? io_o[1] : idle_pat;
   sfr_host host (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk), .io0_o(io0),
      .so_i(so_line));
   sfr_regs #(.STATUS_WRITE_TIME_NS(TW_NS)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .ce_i(ce), .cs_n_i(cs_n), .sclk_i(sclk), .io_i({1'b1, wp_n, so_line, io0}),
      .io_o(io_o), .io_oe_o(io_oe_o), .four_line_i(1'b0), .option_d_i(opt_d),
      .program_busy_i(pbusy), .erase_busy_i(ebusy), .status_o(status_o), .cfg_o(cfg_o),
      .prot_o(prot_o), .write_in_progress_o(write_in_progress), .drive_strength_o(drv),
      .pin_hold_o(hold), .pin_reset_o(rstp), .pin_data_o(), .page_wrap_mask_o(wrap),
      .page_erase_o(pe), .page_erase_wide_o(pe_wide), .block_lock_preset_o(preset));
   // system clock, 8 ns
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // line pattern, erase pulse count and hang guard
   always @(posedge clk_sys_i) begin
      idle_pat <= ~idle_pat;
      cycles <= cycles + 1;
      if (pe === 1'b1) pe_count <= pe_count + 1;
      if (cycles == 30000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // expected status after an accepted write of 16 or 8 data bits
   function automatic logic [15:0] wr_exp(input logic [15:0] old, input logic [15:0] d,
                                          input bit wide);
      logic [15:0] n;
      n = old;
      if (wide) begin
         n = (old & 16'h8403) | (d & 16'h7BFC);
         n[13:11] = old[13:11] | d[13:11];
      end else begin
         n[7:2] = d[7:2];
         n[14] = 1'b0;
         n[9:8] = 2'b00;
      end
      return n;
   endfunction
   task automatic wait_idle();
      for (int i = 0; i < 400 && write_in_progress !== 1'b0; i++) @(negedge clk_sys_i);
      chk("busy end", 16'h0000, 16'(write_in_progress));
   endtask
   task automatic write_enable_command();
      host.xfer(OP_WRITE_ENABLE, 16'h0000, 0, 0, 0, rd);
      chk("latch", 16'h0002, 16'(status_o[1:0]));
   endtask
   // latch, write, busy check, config read while busy, then settle
   task automatic swr(input logic [7:0] op, input logic [15:0] d, input int n, input bit ok);
      write_enable_command();
      host.xfer(op, n == 16 ? {d[7:0], d[15:8]} : {d[7:0], 8'h00}, n, 0, 0, rd);
      chk("busy", 16'(ok), 16'(write_in_progress));
      host.xfer(OP_CONFIG_READ, 16'h0000, 0, 8, 0, rd);
      chk("config read", 16'(exp_cfg), 16'(rd));
      wait_idle();
      if (ok) exp_st = wr_exp(exp_st, d, n == 16);
      chk("status", exp_st | (ok ? 16'h0000 : 16'h0002), status_o);
      chk("prot", 16'(exp_st[14:11]), 16'({prot_o.complement, prot_o.sec_lock}));
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      {ce, rst_i, wp_n, opt_d, pbusy, ebusy, idle_pat} = 7'b1110000;
      {bad_count, samples_checked, cycles, pe_count} = '0;
      {seed, exp_st, exp_cfg} = {32'h18035BA5, 16'h0000, 8'h40};
      repeat (20) @(negedge clk_sys_i);
      chk("lock preset", 16'h0001, 16'(preset));
      rst_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk("status reset", 16'h0000, status_o);
      chk("config reset", 16'h0040, 16'(cfg_o));
      chk("pins", 16'h00FF, {5'h00, preset, wrap});
      chk("hold", 16'h0001, 16'(hold));
      // write with no latch is ignored
      host.xfer(OP_STATUS_WRITE_A, 16'h7C7C, 16, 0, 0, rd);
      chk("no latch", 16'h0000, status_o);
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         swr(k[0] ? OP_STATUS_WRITE_B : OP_STATUS_WRITE_A, seed[15:0] & 16'hFE7F, 16, 1);
      end
      seed = xs(seed);
      swr(OP_STATUS_WRITE_A, seed[15:0], 12, 0);
      swr(OP_STATUS_WRITE_B, 16'h00FC, 8, 1);
      wp_n = 1'b0;
      swr(OP_STATUS_WRITE_A, 16'h4A30, 16, 0);
      wp_n = 1'b1;
      swr(OP_STATUS_WRITE_A, 16'h0000, 8, 1);
      // config: reset pin, drive 01, wide page, lock scheme
      write_enable_command();
      host.xfer(OP_CONFIG_WRITE, 16'hB400, 8, 0, 0, rd);
      // a frozen block must hold its write cycle past its normal end
      ce = 1'b0;
      repeat (300) @(negedge clk_sys_i);
      chk("frozen busy", 16'h0001, 16'(write_in_progress));
      ce = 1'b1;
      wait_idle();
      exp_cfg = 8'hB4;
      chk("config", 16'h00B4, 16'(cfg_o));
      chk("pin and drive", 16'h0013, 16'({rstp, hold, drv, prot_o.scheme}));
      chk("wide", 16'h07FF, {5'h00, pe_wide, wrap});
      host.xfer(OP_PAGE_ERASE, 16'h0000, 0, 0, 0, rd);
      chk("erase pulse", 16'h0001, 16'(pe_count));
      opt_d = 1'b1;
      host.xfer(OP_CONFIG_READ_D, 16'h0000, 0, 8, 0, rd);
      chk("option d read", 16'h00B4, 16'(rd));
      chk("option d drive", 16'h0002, 16'(drv));
      opt_d = 1'b0;
      // suspend and resume for erase then program
      for (int k = 0; k < 2; k++) begin
         {ebusy, pbusy} = k ? 2'b01 : 2'b10;
         host.xfer(k ? OP_SUSPEND_B : OP_SUSPEND_A, 16'h0000, 0, 0, 0, rd);
         chk("suspend", k ? 16'h0400 : 16'h8000, status_o & 16'h8400);
         {ebusy, pbusy} = 2'b00;
         host.xfer(k ? OP_RESUME_B : OP_RESUME_A, 16'h0000, 0, 0, 0, rd);
         chk("resume", 16'h0000, status_o & 16'h8400);
      end
      // status wait follows busy with no clocks, released by select
      ebusy = 1'b1;
      host.xfer(OP_STATUS_WAIT, 16'h0000, 0, 0, 1, rd);
      chk("wait busy", 16'h0003, 16'({io_oe_o[1], io_o[1]}));
      ebusy = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      chk("wait done", 16'h0002, 16'({io_oe_o[1], io_o[1]}));
      host.cs_up();
      chk("released", 16'h0000, 16'(io_oe_o));
      tally_and_finish();
   end
endmodule // serial_flash_status_config_regs_tb
